// file: design/ppoc_port_power_ctl.sv
// Port power control and over-current sensing for the downstream ports of a hub.
// Assumes pins are resolved outside: output enable high means the pin is driven.
module ppoc_port_power_ctl
    import ppoc_pkg::*;
#(
    parameter int NUM_PORTS = PPOC_NUM_PORTS,
    parameter int FILT_LEN_W = PPOC_FILT_LEN_W
) (
    // Clock, enable and reset.
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic rst_n,
    // Register port.
    input wire logic [PPOC_ADDR_W-1:0] reg_addr,
    input wire logic [PPOC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PPOC_DATA_W-1:0] reg_rdata,
    // Per-port power control pins.
    input wire logic [NUM_PORTS-1:0] port_power_ctl_pin_i,
    output logic [NUM_PORTS-1:0] port_power_ctl_pin_o,
    output logic [NUM_PORTS-1:0] port_power_ctl_pin_oe,
    output logic [NUM_PORTS-1:0] port_pullup_en,
    // Shared power control pin for ganged mode.
    input wire logic shared_power_ctl_pin_i,
    output logic shared_power_ctl_pin_o,
    output logic shared_power_ctl_pin_oe,
    output logic shared_pullup_en,
    // Battery charging strap, active low.
    input wire logic charge_enable_strap_n,
    // Outputs to the hub core.
    output logic [NUM_PORTS-1:0] charge_en,
    output logic [7:0] pwr_good_dly,
    output logic irq
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    // Every flip-flop of the block apart from the filter instances lives in this one record.
    typedef struct packed {
        logic [1:0] ctrl;                  // Mode and poly-fuse selects.
        logic [NUM_PORTS-1:0] pwr_en;      // Requested port power.
        logic [NUM_PORTS-1:0] oc_status;   // Sticky over-current flags.
        logic [NUM_PORTS-1:0] oc_mask;     // Interrupt enables, same layout.
        logic [FILT_LEN_W-1:0] filt_len;   // Filter length in cycles.
        logic [7:0] dly_cfg;               // Configured power-good delay.
        logic [7:0] dly_eff;               // Delay reported to the core.
        logic [NUM_PORTS-1:0] port_sync1;  // First synchroniser stage, ports.
        logic [NUM_PORTS-1:0] port_sync2;  // Second synchroniser stage, ports.
        logic shared_sync1;                // First stage, shared pin.
        logic shared_sync2;                // Second stage, shared pin.
        logic strap_sync1;                 // First stage, strap.
        logic strap_sync2;                 // Second stage, strap.
        ppoc_strap_st_t strap_st;          // Strap capture state.
        logic [1:0] strap_cnt;             // Settling count for the strap.
        logic [NUM_PORTS-1:0] charge;      // Latched charging enables.
        logic [NUM_PORTS-1:0] port_oe;     // Port pin drive enables.
        logic [NUM_PORTS-1:0] port_pu;     // Port pull-up enables.
        logic shared_oe;                   // Shared pin drive enable.
        logic shared_pu;                   // Shared pull-up enable.
        logic irq;                         // Interrupt output.
        logic [PPOC_DATA_W-1:0] rdata;     // Read data, valid one cycle.
    } ppoc_state_t;

    ppoc_state_t st_r;
    ppoc_state_t st_nxt;

    // Filter outputs, one per port and one for the shared pin.
    logic [NUM_PORTS-1:0] port_evt;
    logic shared_evt;
    // Over-current events as seen by each port.
    logic [NUM_PORTS-1:0] evt_ports;
    // Decoded mode.
    ppoc_mode_t mode;

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Decode the mode from the control field.
    function automatic ppoc_mode_t ppoc_mode_of(input logic [1:0] ctrl);
        ppoc_mode_of = ctrl[PPOC_CTRL_GANGED_BIT] ? PPOC_MODE_GANGED : PPOC_MODE_COMBINED;
    endfunction

    // Widen a port vector to a register word.
    function automatic logic [PPOC_DATA_W-1:0] ppoc_port_word(input logic [NUM_PORTS-1:0] v);
        ppoc_port_word = '0;
        ppoc_port_word[NUM_PORTS-1:0] = v;
    endfunction

    assign mode = ppoc_mode_of(st_r.ctrl);

    // -------------------------------------------------------------------------
    // Over-current filters
    // -------------------------------------------------------------------------
    // Each filter only listens while its pin is released, so our own low drive
    // when power is off is never taken for an over-current while the filter length is 3 or more.
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port_filt
        ppoc_oc_filter #(
            .LEN_W(FILT_LEN_W)
        ) u_filt (
            .sys_clk(sys_clk),
            .ce(ce),
            .rst_n(rst_n),
            .active(st_r.port_pu[g]),
            .low_lvl(!st_r.port_sync2[g]),
            .len(st_r.filt_len),
            .evt(port_evt[g])
        );
    end

    ppoc_oc_filter #(
        .LEN_W(FILT_LEN_W)
    ) u_shared_filt (
        .sys_clk(sys_clk),
        .ce(ce),
        .rst_n(rst_n),
        .active(st_r.shared_pu),
        .low_lvl(!st_r.shared_sync2),
        .len(st_r.filt_len),
        .evt(shared_evt)
    );

    // A shared-pin event trips every port together.
    assign evt_ports = port_evt | {NUM_PORTS{shared_evt}};

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    // Register writes, reads, event capture, pin control and strap capture.
    always_comb begin
        logic [NUM_PORTS-1:0] port_on;
        logic shared_on;
        logic [PPOC_DATA_W-1:0] pins;
        port_on = '0;
        shared_on = 1'b0;
        pins = '0;
        st_nxt = st_r;
        st_nxt.rdata = '0;

        // Synchronisers: first stage feeds only the second.
        st_nxt.port_sync1 = port_power_ctl_pin_i;
        st_nxt.port_sync2 = st_r.port_sync1;
        st_nxt.shared_sync1 = shared_power_ctl_pin_i;
        st_nxt.shared_sync2 = st_r.shared_sync1;
        st_nxt.strap_sync1 = charge_enable_strap_n;
        st_nxt.strap_sync2 = st_r.strap_sync1;

        // Register writes; unmapped offsets are ignored.
        if (reg_wr) begin
            if (ppoc_addr_hit(reg_addr, PPOC_OFF_CTRL)) begin
                st_nxt.ctrl = reg_wdata[1:0];
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_PWR_EN)) begin
                st_nxt.pwr_en = reg_wdata[NUM_PORTS-1:0];
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_OC_MASK)) begin
                st_nxt.oc_mask = reg_wdata[NUM_PORTS-1:0];
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_FILT_LEN)) begin
                st_nxt.filt_len = reg_wdata[FILT_LEN_W-1:0];
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_PWR_GOOD_DLY)) begin
                st_nxt.dly_cfg = reg_wdata[7:0];
            end
        end

        // Register reads; the status register clears on read.
        if (reg_rd) begin
            pins[PPOC_PIN_SENSE_LSB +: NUM_PORTS] = st_r.port_sync2;
            pins[PPOC_PIN_ON_LSB +: NUM_PORTS] = st_r.port_pu;
            pins[PPOC_PIN_SHARED_BIT] = st_r.shared_sync2;
            pins[PPOC_PIN_SHARED_ON_BIT] = st_r.shared_pu;
            pins[PPOC_PIN_CHARGE_LSB +: NUM_PORTS] = st_r.charge;
            pins[PPOC_PIN_STRAP_DONE_BIT] = (st_r.strap_st == PPOC_STRAP_HELD);
            if (ppoc_addr_hit(reg_addr, PPOC_OFF_CTRL)) begin
                st_nxt.rdata = {30'h0, st_r.ctrl};
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_PWR_EN)) begin
                st_nxt.rdata = ppoc_port_word(st_r.pwr_en);
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_OC_STATUS)) begin
                st_nxt.rdata = ppoc_port_word(st_r.oc_status);
                st_nxt.oc_status = '0;
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_OC_MASK)) begin
                st_nxt.rdata = ppoc_port_word(st_r.oc_mask);
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_FILT_LEN)) begin
                st_nxt.rdata = {{(PPOC_DATA_W-FILT_LEN_W){1'b0}}, st_r.filt_len};
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_PIN_STATE)) begin
                st_nxt.rdata = pins;
            end else if (ppoc_addr_hit(reg_addr, PPOC_OFF_PWR_GOOD_DLY)) begin
                st_nxt.rdata = {24'h0, st_r.dly_eff};
            end
        end

        // flag and remove power
        // A new event beats both the read clear and a write of power.
        st_nxt.oc_status = st_nxt.oc_status | evt_ports;
        st_nxt.pwr_en = st_nxt.pwr_en & ~evt_ports;

        st_nxt.dly_eff = st_nxt.ctrl[PPOC_CTRL_POLY_BIT] ? 8'h00 : st_nxt.dly_cfg;

        // Power each pin according to the mode now in force.
        if (ppoc_mode_of(st_nxt.ctrl) == PPOC_MODE_GANGED) begin
            shared_on = |st_nxt.pwr_en;
        end else begin
            port_on = st_nxt.pwr_en;
        end

        st_nxt.port_oe = ~port_on;
        st_nxt.port_pu = port_on;
        st_nxt.shared_oe = !shared_on;
        st_nxt.shared_pu = shared_on;

        // Interrupt follows the unmasked sticky flags.
        st_nxt.irq = |(st_nxt.oc_status & st_nxt.oc_mask);

        // Strap capture once its synchroniser has settled after reset.
        case (st_r.strap_st)
            PPOC_STRAP_SYNC: begin
                if (st_r.strap_cnt == PPOC_STRAP_WAIT_CYCLES) begin
                    st_nxt.charge = st_r.strap_sync2 ? '0 : PPOC_CHARGE_PORTS[NUM_PORTS-1:0];
                    st_nxt.strap_st = PPOC_STRAP_HELD;
                end else begin
                    st_nxt.strap_cnt = 2'(st_r.strap_cnt + 1'b1);
                end
            end
            default: begin
                st_nxt.strap_st = PPOC_STRAP_HELD;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    // Reset leaves every pin driven low with pull-ups off, so no port is powered.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ctrl <= PPOC_CTRL_RST;
            st_r.filt_len <= PPOC_FILT_LEN_RST;
            st_r.dly_cfg <= PPOC_PWR_GOOD_DLY_RST;
            st_r.dly_eff <= PPOC_PWR_GOOD_DLY_RST;
            st_r.port_oe <= '1;
            st_r.shared_oe <= 1'b1;
            st_r.strap_st <= PPOC_STRAP_SYNC;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state record; the driven level is always low.
    assign reg_rdata = st_r.rdata;
    assign port_power_ctl_pin_o = '0;
    assign port_power_ctl_pin_oe = st_r.port_oe;
    assign port_pullup_en = st_r.port_pu;
    assign shared_power_ctl_pin_o = 1'b0;
    assign shared_power_ctl_pin_oe = st_r.shared_oe;
    assign shared_pullup_en = st_r.shared_pu;
    assign charge_en = st_r.charge;
    assign pwr_good_dly = st_r.dly_eff;
    assign irq = st_r.irq;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    property p_off_drives_low;
        @(posedge sys_clk) disable iff (!rst_n) ((~st_r.port_pu & ~st_r.port_oe) == '0) && ((st_r.port_pu & st_r.port_oe) == '0);
    endproperty
    a_off_drives_low: assert property (p_off_drives_low) else $error("port pin neither driven nor pulled up");

    property p_on_releases;
        @(posedge sys_clk) disable iff (!rst_n) st_r.shared_pu |-> !st_r.shared_oe;
    endproperty
    a_on_releases: assert property (p_on_releases) else $error("shared pin driven while powered");

    sequence s_oc_event;
        ce && (|evt_ports);
    endsequence

    property p_trip_power_off;
        @(posedge sys_clk) disable iff (!rst_n) s_oc_event |=> ((st_r.pwr_en & $past(evt_ports)) == '0);
    endproperty
    a_trip_power_off: assert property (p_trip_power_off) else $error("power kept after over-current");

    property p_trip_pin_low;
        @(posedge sys_clk) disable iff (!rst_n) s_oc_event |=> ((st_r.port_oe & $past(evt_ports)) == $past(evt_ports));
    endproperty
    a_trip_pin_low: assert property (p_trip_pin_low) else $error("pin released after over-current");

    property p_trip_flag;
        @(posedge sys_clk) disable iff (!rst_n) s_oc_event |=> ((st_r.oc_status & $past(evt_ports)) == $past(evt_ports));
    endproperty
    a_trip_flag: assert property (p_trip_flag) else $error("over-current flag not set");

    property p_poly_delay;
        @(posedge sys_clk) disable iff (!rst_n) st_r.ctrl[PPOC_CTRL_POLY_BIT] |-> (pwr_good_dly == 8'h00);
    endproperty
    a_poly_delay: assert property (p_poly_delay) else $error("power-good delay not zero with poly fuse");

    property p_ganged_ports_off;
        @(posedge sys_clk) disable iff (!rst_n) (mode == PPOC_MODE_GANGED) |-> (st_r.port_oe == '1);
    endproperty
    a_ganged_ports_off: assert property (p_ganged_ports_off) else $error("port pin powered in ganged mode");

    property p_combined_shared_off;
        @(posedge sys_clk) disable iff (!rst_n) (mode == PPOC_MODE_COMBINED) |-> st_r.shared_oe;
    endproperty
    a_combined_shared_off: assert property (p_combined_shared_off) else $error("shared pin powered in combined mode");

    property p_status_read;
        @(posedge sys_clk) disable iff (!rst_n)
            (ce && reg_rd && ppoc_addr_hit(reg_addr, PPOC_OFF_OC_STATUS)) |=> (reg_rdata == ppoc_port_word($past(st_r.oc_status)));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read data wrong");

    property p_strap_charge;
        @(posedge sys_clk) disable iff (!rst_n)
            $rose(st_r.strap_st == PPOC_STRAP_HELD) |-> (charge_en == ($past(st_r.strap_sync2) ? '0 : PPOC_CHARGE_PORTS[NUM_PORTS-1:0]));
    endproperty
    a_strap_charge: assert property (p_strap_charge) else $error("charge enables do not follow strap");

endmodule

// file: design/ppoc_pkg.sv
// Constants, register map and shared types of the port power and over-current controller.
// Assumes a single 25 MHz system clock and an active-low asynchronous reset in every user.
package ppoc_pkg;

    // -------------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------------
    // Default number of downstream ports; the register layout holds at most this many.
    localparam int PPOC_NUM_PORTS = 4;
    // Register port address and data widths.
    localparam int PPOC_ADDR_W = 8;
    localparam int PPOC_DATA_W = 32;
    // Width of the over-current filter length field.
    localparam int PPOC_FILT_LEN_W = 16;

    // -------------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------------
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_CTRL = 8'h00;
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_PWR_EN = 8'h04;
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_OC_STATUS = 8'h08;
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_OC_MASK = 8'h0C;
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_FILT_LEN = 8'h10;
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_PIN_STATE = 8'h14;
    localparam logic [PPOC_ADDR_W-1:0] PPOC_OFF_PWR_GOOD_DLY = 8'h18;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    // Control register: ganged mode select and poly-fuse operation.
    localparam int PPOC_CTRL_GANGED_BIT = 0;
    localparam int PPOC_CTRL_POLY_BIT = 1;
    // Pin state register: sensed port levels, port power, shared level, strap.
    localparam int PPOC_PIN_SENSE_LSB = 0;
    localparam int PPOC_PIN_ON_LSB = 4;
    localparam int PPOC_PIN_SHARED_BIT = 8;
    localparam int PPOC_PIN_SHARED_ON_BIT = 9;
    localparam int PPOC_PIN_CHARGE_LSB = 12;
    localparam int PPOC_PIN_STRAP_DONE_BIT = 16;

    // -------------------------------------------------------------------------
    // Reset values and timing
    // -------------------------------------------------------------------------
    localparam logic [1:0] PPOC_CTRL_RST = 2'h0;
    localparam logic [7:0] PPOC_PWR_GOOD_DLY_RST = 8'h32;
    // Default filter time, and the clock period it is counted in.
    localparam int PPOC_OC_FILT_TIME_NS = 4000;
    localparam int PPOC_SYS_CLK_PERIOD_NS = 40;
    // Least time, so rounded up to whole cycles.
    localparam int PPOC_OC_FILT_CYCLES = (PPOC_OC_FILT_TIME_NS + PPOC_SYS_CLK_PERIOD_NS - 1) / PPOC_SYS_CLK_PERIOD_NS;
    localparam logic [PPOC_FILT_LEN_W-1:0] PPOC_FILT_LEN_RST = PPOC_FILT_LEN_W'(PPOC_OC_FILT_CYCLES);
    // Cycles the strap is allowed to settle through its synchroniser before it is caught.
    localparam logic [1:0] PPOC_STRAP_WAIT_CYCLES = 2'h3;
    // Ports that receive battery charging when the strap reads low (ports 0 and 1).
    localparam logic [PPOC_NUM_PORTS-1:0] PPOC_CHARGE_PORTS = 4'h3;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    // Port control mode.
    typedef enum logic {PPOC_MODE_COMBINED, PPOC_MODE_GANGED} ppoc_mode_t;
    // Strap capture sequence.
    typedef enum logic {PPOC_STRAP_SYNC, PPOC_STRAP_HELD} ppoc_strap_st_t;

    // Address match for the register port.
    function automatic logic ppoc_addr_hit(input logic [PPOC_ADDR_W-1:0] addr, input logic [PPOC_ADDR_W-1:0] off);
        ppoc_addr_hit = (addr == off);
    endfunction

endpackage

// file: design/ppoc_oc_filter.sv
// Over-current filter for one sense line: counts consecutive low samples and fires once.
// Assumes its level input is already synchronised to sys_clk.
module ppoc_oc_filter
    import ppoc_pkg::*;
#(
    parameter int LEN_W = PPOC_FILT_LEN_W
) (
    // Clock, enable and reset.
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic rst_n,
    // Sense inputs.
    input wire logic active,
    input wire logic low_lvl,
    input wire logic [LEN_W-1:0] len,
    // Filtered event, one cycle long.
    output logic evt
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [LEN_W-1:0] cnt;
        logic fired;
        logic evt;
    } ppoc_filt_st_t;

    ppoc_filt_st_t st_r;
    ppoc_filt_st_t st_nxt;
    logic [LEN_W-1:0] lim_m1;

    // A length of zero behaves as one so the filter always needs one sample.
    assign lim_m1 = (len == '0) ? '0 : LEN_W'(len - 1'b1);

    // Next state: any high sample or loss of power restarts the count.
    always_comb begin
        st_nxt = st_r;
        st_nxt.evt = 1'b0;
        if (!(active && low_lvl)) begin
            st_nxt.cnt = '0;
            st_nxt.fired = 1'b0;
        end else if (!st_r.fired) begin
            if (st_r.cnt >= lim_m1) begin
                st_nxt.evt = 1'b1;
                st_nxt.fired = 1'b1;
            end else begin
                st_nxt.cnt = LEN_W'(st_r.cnt + 1'b1);
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign evt = st_r.evt;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    property p_evt_needs_low;
        @(posedge sys_clk) disable iff (!rst_n) $rose(st_r.evt) |-> $past(active && low_lvl);
    endproperty
    a_evt_needs_low: assert property (p_evt_needs_low) else $error("filter fired without a low sample");

    property p_evt_count;
        @(posedge sys_clk) disable iff (!rst_n) $rose(st_r.evt) |-> ($past(st_r.cnt) == $past(lim_m1));
    endproperty
    a_evt_count: assert property (p_evt_count) else $error("filter fired before the length elapsed");

    sequence s_evt_taken;
        ce && st_r.evt;
    endsequence
    property p_evt_single;
        @(posedge sys_clk) disable iff (!rst_n) s_evt_taken |=> !st_r.evt;
    endproperty
    a_evt_single: assert property (p_evt_single) else $error("filter event longer than one cycle");

endmodule

// file: tb/ppoc_switch_model.sv
// Behavioural external power switch, one channel per port pin.
// Assumes the device's drive and pull-up enables are wired straight in.
module ppoc_switch_model (
    // Device side.
    input wire logic [3:0] drive_low,
    input wire logic [3:0] pullup_en,
    // Fault command from the bench.
    input wire logic [3:0] fault,
    // Resolved pin level.
    output logic [3:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    assign level = ~drive_low & ~fault & pullup_en;
endmodule

// file: tb/port_power_overcurrent_ctl_tb.sv
// Self-checking bench for the port power and over-current controller.
// Assumes a switch model on the port pins and the strap tied low.
module port_power_overcurrent_ctl_tb import ppoc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] e;} ppoc_row_t;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, shd_pu, irq, ce = 1, sfault = 0;
    logic [7:0] reg_addr = 8'h00, pgd;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
    logic [3:0] fault = 4'h0, lvl, oe, pu, chg;
    int err_total = 0, checks_done = 0;
    // Reset values, pin state once the strap is caught, plus an unmapped address that reads zero.
    ppoc_row_t rows[8] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h0C, 32'h0}, '{8'h08, 32'h0},
        '{8'h10, 32'h64}, '{8'h18, 32'h32}, '{8'h14, 32'h13000}, '{8'h20, 32'h0}};
    ppoc_switch_model u_sw (.drive_low(oe), .pullup_en(pu), .fault(fault), .level(lvl));
    ppoc_port_power_ctl u_dut (.sys_clk(sys_clk), .ce(ce), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_power_ctl_pin_i(lvl), .port_power_ctl_pin_o(), .port_power_ctl_pin_oe(oe),
        .port_pullup_en(pu), .shared_power_ctl_pin_i(shd_pu & ~sfault), .shared_power_ctl_pin_o(),
        .shared_power_ctl_pin_oe(), .shared_pullup_en(shd_pu), .charge_enable_strap_n(1'b0),
        .charge_en(chg), .pwr_good_dly(pgd), .irq(irq));
    // Free-running system clock.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Prints the verdict and ends the run.
    task automatic test_done();
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Compares one value and counts it.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One-cycle write, then lets the result settle.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // One-cycle read; data is taken in the following cycle.
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    // Main sequence.
    initial begin
        repeat (12) @(posedge sys_clk);
        chk("oe_rst", 32'hF, oe);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        foreach (rows[i]) begin
            rd(rows[i].a);
            chk("reg", rows[i].e, q);
        end
        chk("charge", 32'h3, chg);
        wr(8'h04, 32'hF);
        chk("oe_on", 32'h0, oe);
        chk("pu_on", 32'hF, pu);
        wr(8'h10, 32'h3);
        wr(8'h0C, 32'h1);
        fault <= 4'h1;
        repeat (2) @(posedge sys_clk);
        fault <= 4'h0;
        repeat (10) @(posedge sys_clk);
        #1 chk("irq_glitch", 32'h0, irq);
        fault <= 4'h1;
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge sys_clk);
        chk("irq_oc", 32'h1, irq);
        if (irq !== 1'b1) test_done();
        fault <= 4'h0;
        repeat (2) @(posedge sys_clk);
        #1 chk("oe_oc", 32'h1, oe);
        rd(8'h08);
        chk("status", 32'h1, q);
        chk("irq_clr", 32'h0, irq);
        @(posedge sys_clk);
        #1 chk("rdata_idle", 32'h0, reg_rdata);
        wr(8'h00, 32'h2);
        chk("pgd_poly", 32'h0, pgd);
        chk("pu_poly", 32'hE, pu);
        wr(8'h00, 32'h1);
        chk("shared_pu", 32'h1, shd_pu);
        chk("oe_gang", 32'hF, oe);
        // Shared over-current trips every port together.
        @(posedge sys_clk) sfault <= 1'b1;
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge sys_clk);
        sfault <= 1'b0;
        rd(8'h08);
        chk("status_gang", 32'hF, q);
        chk("shared_off", 32'h0, shd_pu);
        // Strobes are ignored while the clock enable is low.
        @(posedge sys_clk) ce <= 1'b0;
        wr(8'h0C, 32'h0);
        @(posedge sys_clk) ce <= 1'b1;
        rd(8'h0C);
        chk("mask_frozen", 32'h1, q);
        test_done();
    end
endmodule
